/* verilog/serial_port_regs.svh */
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH
// register byte offsets
`define CTRL0_OFS 8'h00
`define CTRL1_OFS 8'h04
`define STATUS_OFS 8'h08
`define DATA_OFS 8'h0C
// port_control_zero fields
`define C0_ENABLE 0
`define C0_PACK 1
`define C0_AUDIO 2
`define C0_EXT 3
`define C0_NET 4
`define C0_FAST 5
`define C0_SLAVE 6
`define C0_TXIE 7
`define C0_RXIE 8
`define C0_DIV_LSB 16
// port_control_one fields
`define C1_TFT_LSB 0
`define C1_RFT_LSB 4
`define TRIG_W 4
// port_status_reg fields
`define ST_TXCNT_LSB 0
`define ST_RXCNT_LSB 8
`define ST_TXFULL 16
`define ST_TXEMPTY 17
`define ST_RXFULL 18
`define ST_RXEMPTY 19
`define ST_TXREQ 20
`define ST_RXREQ 21
`define ST_OVR 22
// reset values
`define CTRL0_RESET 32'h0000_0000
`define CTRL1_RESET 32'h0000_0000
`endif

/* verilog/serial_port_pkg.sv */
`default_nettype none
package serial_port_pkg;
    typedef enum logic [2:0] {
        SRC_SLOW,
        SRC_FAST,
        SRC_NET,
        SRC_EXT,
        SRC_AUDIO
    } clk_source_type;
endpackage
`default_nettype wire

/* verilog/serial_port_fifo_baud.sv */
// Behaviour
// [R1] separate independent transmit and receive queues, filled or drained by bus accesses
// [R2] receive request raised while receive count exceeds rx_trigger_level
// [R3] transmit request raised while transmit count is at most tx_trigger_level plus one
// [R4] status register shows sample counts and full and empty of both queues
// [R5] overfilled transmit queue or over-read receive queue raises no flag
// [R6] no flow control; every bus access is answered, shifting never waits
// [R7] dma burst must stay below trigger level, requests prioritised by system
// [R8] unpacked, one sample per location, sixteen locations per queue
// [R9] packed, two samples per location, sixteen locations, word-wide dma
// [R10] dma width code 01, 10 or 11 by sample size when unpacked
// [R11] program dma, then controls, then port enable, then start dma
// [R12] full duplex receives as many samples as it transmits
// [R13] software pairs trigger levels with burst sizes per sample width
// [R14] packed mode doubles the meaning of both trigger level fields
// [R15] as clock master, bit clock is selected source divided by rate divider
// [R16] source priority audio, then network, then external, else slow on-chip
// [R17] no selects with fast_clock_select set uses fast on-chip clock
// [R18] audio source passes through the same divider, losing audio phase alignment
// [R19] source change: disable port, gate clock, write selects, ungate, enable
// [R20] rate change: disable, write divider, enable, wait two bit clocks
// [R21] samples right-justified, unused receive bits above msb read zero
// [R22] receive overrun sets rx_overrun_flag and drops the new sample
// [R23] requests fall as soon as their level condition stops holding
//
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_regs.svh"
module serial_port_fifo_baud #(
    parameter int DEPTH = 16,
    parameter int DIVW = 12
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // shifter side
    input wire logic TX_POP,
    output logic [31:0] TX_DATA,
    output logic TX_AVAIL,
    input wire logic RX_PUSH,
    input wire logic [31:0] RX_DATA,
    // service requests
    output logic TX_REQ,
    output logic RX_REQ,
    output logic TX_INT,
    output logic RX_INT,
    // baud sources
    input wire logic SLOW_CLK_IN,
    input wire logic FAST_CLK_IN,
    input wire logic NET_CLK_IN,
    input wire logic EXT_CLK_IN,
    input wire logic AUDIO_CLK_IN,
    // serial bit clock
    output logic BIT_CLK_O,
    output logic BIT_CLK_OE
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam int SW = AW + 2;
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][31:0] txm;
        logic [AW-1:0] tx_wp;
        logic [AW-1:0] tx_rp;
        logic [CW-1:0] tx_cnt;
        logic tx_half;
        logic [DEPTH-1:0][31:0] rxm;
        logic [AW-1:0] rx_wp;
        logic [AW-1:0] rx_rp;
        logic [CW-1:0] rx_cnt;
        logic rx_half;
        logic [15:0] rx_low;
        logic [31:0] c0;
        logic [31:0] c1;
        logic ovr;
        logic ack;
        logic [31:0] rdat;
        logic [4:0] s1;
        logic [4:0] s2;
        logic [4:0] s3;
        logic [DIVW-1:0] bcnt;
        logic bclk;
    } state_type;

    state_type q_q;
    state_type d_d;
    serial_port_pkg::clk_source_type src;
    logic en, pack, acc, src_edge, tx_push, tx_pop, rx_pop;
    logic [31:0] wmask;
    logic [SW-1:0] tx_samp, rx_samp, tx_lim, rx_lim, t1;
    logic [`TRIG_W-1:0] tx_trigger_level, rx_trigger_level;
    logic [DIVW-1:0] div;

    always_comb begin
        d_d = q_q;
        en = q_q.c0[`C0_ENABLE];
        pack = q_q.c0[`C0_PACK];
        tx_trigger_level = q_q.c1[`C1_TFT_LSB +: `TRIG_W];
        rx_trigger_level = q_q.c1[`C1_RFT_LSB +: `TRIG_W];
        div = q_q.c0[`C0_DIV_LSB +: DIVW];
        // source select
        if (q_q.c0[`C0_AUDIO]) begin // [R16] [R18]
            src = serial_port_pkg::SRC_AUDIO;
        end else if (q_q.c0[`C0_NET]) begin // [R16]
            src = serial_port_pkg::SRC_NET;
        end else if (q_q.c0[`C0_EXT]) begin // [R16]
            src = serial_port_pkg::SRC_EXT;
        end else if (q_q.c0[`C0_FAST]) begin // [R17]
            src = serial_port_pkg::SRC_FAST;
        end else begin
            src = serial_port_pkg::SRC_SLOW; // [R16]
        end
        // source synchronisers
        d_d.s1 = {AUDIO_CLK_IN, EXT_CLK_IN, NET_CLK_IN, FAST_CLK_IN, SLOW_CLK_IN};
        d_d.s2 = q_q.s1;
        d_d.s3 = q_q.s2;
        src_edge = q_q.s2[src] & ~q_q.s3[src];
        // baud divider
        if (!en || q_q.c0[`C0_SLAVE]) begin
            d_d.bcnt = '0;
            d_d.bclk = 1'b0;
        end else if (src_edge) begin
            if (q_q.bcnt >= div) begin // [R15]
                d_d.bcnt = '0;
                d_d.bclk = ~q_q.bclk;
            end else begin
                d_d.bcnt = q_q.bcnt + DIVW'(1);
            end
        end
        // levels in samples
        tx_samp = pack ? SW'({q_q.tx_cnt, 1'b0}) - SW'(q_q.tx_half) : SW'(q_q.tx_cnt); // [R9]
        rx_samp = pack ? SW'({q_q.rx_cnt, 1'b0}) + SW'(q_q.rx_half) : SW'(q_q.rx_cnt); // [R9]
        t1 = SW'(tx_trigger_level) + SW'(1);
        tx_lim = pack ? SW'({t1, 1'b0}) : t1; // [R14]
        rx_lim = pack ? SW'({rx_trigger_level, 1'b0}) : SW'(rx_trigger_level); // [R14]
        // bus access
        acc = WB_CYC_I & WB_STB_I & ~q_q.ack; // [R6]
        wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
        tx_push = 1'b0;
        rx_pop = 1'b0;
        tx_pop = 1'b0;
        d_d.ack = acc;
        if (acc && WB_WE_I) begin
            case (WB_ADR_I)
                `CTRL0_OFS: d_d.c0 = (q_q.c0 & ~wmask) | (WB_DAT_I & wmask);
                `CTRL1_OFS: d_d.c1 = (q_q.c1 & ~wmask) | (WB_DAT_I & wmask);
                `STATUS_OFS: begin
                    if (WB_SEL_I[2] && WB_DAT_I[`ST_OVR]) begin
                        d_d.ovr = 1'b0;
                    end
                end
                `DATA_OFS: tx_push = (q_q.tx_cnt != FULL); // [R5] [R1] [R8]
                default: d_d.ack = acc;
            endcase
        end
        if (acc && !WB_WE_I) begin
            d_d.rdat = '0;
            case (WB_ADR_I)
                `CTRL0_OFS: d_d.rdat = q_q.c0;
                `CTRL1_OFS: d_d.rdat = q_q.c1;
                `STATUS_OFS: begin // [R4]
                    d_d.rdat[`ST_TXCNT_LSB +: SW] = tx_samp;
                    d_d.rdat[`ST_RXCNT_LSB +: SW] = rx_samp;
                    d_d.rdat[`ST_TXFULL] = (q_q.tx_cnt == FULL);
                    d_d.rdat[`ST_TXEMPTY] = (q_q.tx_cnt == '0);
                    d_d.rdat[`ST_RXFULL] = (q_q.rx_cnt == FULL);
                    d_d.rdat[`ST_RXEMPTY] = (q_q.rx_cnt == '0);
                    d_d.rdat[`ST_TXREQ] = en && (tx_samp <= tx_lim);
                    d_d.rdat[`ST_RXREQ] = en && (rx_samp > rx_lim);
                    d_d.rdat[`ST_OVR] = q_q.ovr;
                end
                `DATA_OFS: begin
                    rx_pop = (q_q.rx_cnt != '0); // [R5] [R1]
                    if (rx_pop) begin
                        d_d.rdat = q_q.rxm[q_q.rx_rp];
                    end
                end
                default: d_d.rdat = '0;
            endcase
        end
        if (tx_push) begin
            d_d.txm[q_q.tx_wp] = WB_DAT_I;
            d_d.tx_wp = q_q.tx_wp + AW'(1);
        end
        // shifter takes transmit samples
        if (TX_POP && q_q.tx_cnt != '0) begin // [R6]
            if (pack && !q_q.tx_half) begin // [R9]
                d_d.tx_half = 1'b1;
            end else begin
                d_d.tx_half = 1'b0;
                tx_pop = 1'b1;
                d_d.tx_rp = q_q.tx_rp + AW'(1);
            end
        end
        d_d.tx_cnt = q_q.tx_cnt + CW'(tx_push) - CW'(tx_pop);
        if (rx_pop) begin
            d_d.rx_rp = q_q.rx_rp + AW'(1);
        end
        // shifter delivers receive samples
        d_d.rx_cnt = q_q.rx_cnt - CW'(rx_pop);
        if (RX_PUSH) begin // [R12]
            if (pack && !q_q.rx_half) begin // [R9]
                d_d.rx_low = RX_DATA[15:0];
                d_d.rx_half = 1'b1;
            end else begin
                d_d.rx_half = 1'b0;
                if (q_q.rx_cnt == FULL) begin
                    d_d.ovr = 1'b1; // [R22]
                end else begin
                    d_d.rxm[q_q.rx_wp] = pack ? {RX_DATA[15:0], q_q.rx_low} : RX_DATA; // [R21]
                    d_d.rx_wp = q_q.rx_wp + AW'(1);
                    d_d.rx_cnt = q_q.rx_cnt - CW'(rx_pop) + CW'(1);
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            q_q <= '0;
            q_q.c0 <= `CTRL0_RESET;
            q_q.c1 <= `CTRL1_RESET;
        end else begin
            q_q <= d_d;
        end
    end

    // outputs
    assign WB_DAT_O = q_q.rdat;
    assign WB_ACK_O = q_q.ack;
    assign TX_AVAIL = (q_q.tx_cnt != '0);
    assign TX_DATA = !pack ? q_q.txm[q_q.tx_rp] : // [R21]
        {16'h0000, q_q.tx_half ? q_q.txm[q_q.tx_rp][31:16] : q_q.txm[q_q.tx_rp][15:0]};
    assign TX_REQ = en && (tx_samp <= tx_lim); // [R3] [R23]
    assign RX_REQ = en && (rx_samp > rx_lim); // [R2] [R23]
    assign TX_INT = TX_REQ && q_q.c0[`C0_TXIE]; // [R3]
    assign RX_INT = RX_REQ && q_q.c0[`C0_RXIE]; // [R2]
    assign BIT_CLK_O = q_q.bclk; // [R15]
    assign BIT_CLK_OE = en && !q_q.c0[`C0_SLAVE];

    chk_rx_req_level: assert property (@(posedge CLK) disable iff (!RST_B) // [R2]
        (en && !pack && !q_q.rx_half && q_q.rx_cnt > CW'(rx_trigger_level)) |-> RX_REQ)
        else $error("receive request missing above level");
    chk_tx_req_level: assert property (@(posedge CLK) disable iff (!RST_B) // [R3]
        (en && !pack && q_q.tx_cnt > CW'(tx_trigger_level) + CW'(1)) |-> !TX_REQ)
        else $error("transmit request above level");
    chk_packed_rx_level: assert property (@(posedge CLK) disable iff (!RST_B) // [R14]
        (en && pack && !q_q.rx_half && 2 * q_q.rx_cnt > rx_trigger_level && q_q.rx_cnt <= rx_trigger_level) |->
        !RX_REQ)
        else $error("packed receive level not doubled");
    chk_silent_overfill: assert property (@(posedge CLK) disable iff (!RST_B) // [R5]
        (acc && WB_WE_I && WB_ADR_I == `DATA_OFS && q_q.tx_cnt == FULL && !TX_POP) |=>
        ($stable(q_q.tx_wp) && q_q.tx_cnt == FULL))
        else $error("overfill changed transmit queue");
    chk_bus_answer: assert property (@(posedge CLK) disable iff (!RST_B) // [R6]
        (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O ##1 !WB_ACK_O)
        else $error("bus access not answered in one cycle");
    chk_overrun_drop: assert property (@(posedge CLK) disable iff (!RST_B) // [R22]
        (RX_PUSH && !pack && q_q.rx_cnt == FULL && !rx_pop) |=> (q_q.ovr && $stable(q_q.rx_wp)))
        else $error("overrun not flagged or data kept");
    chk_depth_bound: assert property (@(posedge CLK) disable iff (!RST_B) // [R8]
        (q_q.tx_cnt <= FULL) && (q_q.rx_cnt <= FULL))
        else $error("queue count beyond depth");
    chk_status_count: assert property (@(posedge CLK) disable iff (!RST_B) // [R4]
        (acc && !WB_WE_I && WB_ADR_I == `STATUS_OFS) |=>
        WB_DAT_O[`ST_TXCNT_LSB +: SW] == $past(tx_samp))
        else $error("status count wrong");
    chk_clock_idle: assert property (@(posedge CLK) disable iff (!RST_B) // [R15]
        (!en || q_q.c0[`C0_SLAVE]) |=> !BIT_CLK_O)
        else $error("bit clock runs while not master");
    chk_clock_edge: assert property (@(posedge CLK) disable iff (!RST_B) // [R15]
        (BIT_CLK_O != $past(BIT_CLK_O) && BIT_CLK_OE) |-> $past(src_edge))
        else $error("bit clock toggled without source edge");
    chk_pop_advances: assert property (@(posedge CLK) disable iff (!RST_B) // [R1]
        (TX_POP && !pack && q_q.tx_cnt != '0 && !tx_push) |=>
        (q_q.tx_cnt == $past(q_q.tx_cnt) - CW'(1)))
        else $error("transmit pop did not free a location");
    chk_empty_read_zero: assert property (@(posedge CLK) disable iff (!RST_B) // [R5]
        (acc && !WB_WE_I && WB_ADR_I == `DATA_OFS && q_q.rx_cnt == '0) |=>
        (WB_DAT_O == 32'h0000_0000 && $stable(q_q.rx_rp)))
        else $error("empty receive read not silent");
    chk_req_gated: assert property (@(posedge CLK) disable iff (!RST_B) // [R23]
        !en |-> (!TX_REQ && !RX_REQ))
        else $error("request while port disabled");
    chk_packed_tx_half: assert property (@(posedge CLK) disable iff (!RST_B) // [R9]
        (TX_POP && pack && !q_q.tx_half && q_q.tx_cnt != '0) |=>
        (q_q.tx_half && $stable(q_q.tx_rp)))
        else $error("packed first pop freed a location");
    chk_packed_tx_level: assert property (@(posedge CLK) disable iff (!RST_B) // [R14]
        (en && pack && !q_q.tx_half && 2 * q_q.tx_cnt > tx_trigger_level + 1 && q_q.tx_cnt <= tx_trigger_level + 1) |->
        TX_REQ)
        else $error("packed transmit level not doubled");
endmodule // serial_port_fifo_baud
`default_nettype wire

/* bench/serial_shifter_model.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_shifter_model (
    // clock
    input wire logic CLK,
    // transmit side
    input wire logic TX_AVAIL,
    input wire logic [31:0] TX_DATA,
    output logic TX_POP,
    // receive side
    output logic RX_PUSH,
    output logic [31:0] RX_DATA
);
    initial begin
        TX_POP = 1'b0;
        RX_PUSH = 1'b0;
        RX_DATA = 32'h0;
    end
    // takes the shown sample, never waits for the bus side
    task automatic pop_one(output logic [31:0] v);
        @(posedge CLK);
        v = TX_DATA;
        TX_POP <= TX_AVAIL;
        @(posedge CLK);
        TX_POP <= 1'b0;
    endtask
    // one sample in, data line inverted outside the push
    task automatic push_one(input logic [31:0] v);
        @(posedge CLK);
        RX_DATA <= v;
        RX_PUSH <= 1'b1;
        @(posedge CLK);
        RX_PUSH <= 1'b0;
        RX_DATA <= ~v;
    endtask
endmodule // serial_shifter_model
`default_nettype wire

/* bench/serial_port_fifo_and_baud_gen_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_regs.svh"
module serial_port_fifo_and_baud_gen_bench;
    logic clk, rst_b, cyc, stb, we;
    logic bclk_prev = 1'b0;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, r, v;
    logic [4:0] src = 5'h0;
    wire logic [31:0] dat_o, tx_data, rx_data;
    wire logic ack, tx_pop, tx_avail, rx_push, tx_req, rx_req, tx_int, rx_int, bclk, bclk_oe;
    int n_errors, total_checks, tx_trigger_level, rx_trigger_level, m, d, diff, n0;
    int n_tog = 0;
    int tick = 0;
    int txq[$];
    int rxq[$];
    localparam int HP[5] = '{3, 4, 5, 6, 7};
    localparam int EXP[7] = '{0, 1, 2, 3, 4, 2, 4};
    localparam logic [31:0] SELS[7] = '{32'h0, 32'h20, 32'h10, 32'h8, 32'h4, 32'h18, 32'h34};
    serial_port_fifo_baud dut_u (.CLK(clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .TX_POP(tx_pop), .TX_DATA(tx_data), .TX_AVAIL(tx_avail),
        .RX_PUSH(rx_push), .RX_DATA(rx_data), .TX_REQ(tx_req), .RX_REQ(rx_req),
        .TX_INT(tx_int), .RX_INT(rx_int), .SLOW_CLK_IN(src[0]), .FAST_CLK_IN(src[1]),
        .NET_CLK_IN(src[2]), .EXT_CLK_IN(src[3]), .AUDIO_CLK_IN(src[4]),
        .BIT_CLK_O(bclk), .BIT_CLK_OE(bclk_oe));
    serial_shifter_model sh_u (.CLK(clk), .TX_AVAIL(tx_avail), .TX_DATA(tx_data),
        .TX_POP(tx_pop), .RX_PUSH(rx_push), .RX_DATA(rx_data));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // baud sources and bit clock edge count
    always @(posedge clk) begin
        tick <= tick + 1;
        for (int i = 0; i < 5; i++) if (tick % HP[i] == 0) src[i] <= ~src[i];
        if (bclk !== bclk_prev) n_tog++;
        bclk_prev <= bclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dd,
                      output logic [31:0] q);
        int k;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= dd;
        sel <= 4'hF;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        if (ack !== 1'b1) begin
            n_errors++;
            final_report();
        end
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    function automatic logic [31:0] st(int t, int q, int o);
        return 32'(t) | 32'(q) << 8 | 32'(t == 16) << 16 | 32'(t == 0) << 17 | 32'(q == 16) << 18
            | 32'(q == 0) << 19 | 32'(t <= tx_trigger_level + 1) << 20 | 32'(q > rx_trigger_level) << 21 | 32'(o) << 22;
    endfunction
    initial begin
        {cyc, stb, we} = 3'h0;
        adr = 8'h0;
        sel = 4'h0;
        wdat = 32'h0;
        rst_b = 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        void'($urandom(84049));
        wb(1'b0, `CTRL0_OFS, 32'h0, r);
        chk(r, `CTRL0_RESET);
        wb(1'b0, `CTRL1_OFS, 32'h0, r);
        chk(r, `CTRL1_RESET);
        wb(1'b0, `STATUS_OFS, 32'h0, r);
        chk(r, 32'h000A_0000);
        wb(1'b0, 8'h40, 32'h0, r);
        chk(r, 32'h0);
        chk(tx_avail, 32'h0);
        $display("reset test done");
        m = 1;
        tx_trigger_level = $urandom % 8;
        rx_trigger_level = $urandom % 8;
        wb(1'b1, `CTRL1_OFS, 32'(rx_trigger_level << 4 | tx_trigger_level), r);
        wb(1'b1, `CTRL0_OFS, 32'h0000_0181, r);
        for (int i = 0; i < 17; i++) begin
            v = $urandom;
            wb(1'b1, `DATA_OFS, v, r);
            if (i < 16) txq.push_back(v);
            wb(1'b0, `STATUS_OFS, 32'h0, r);
            chk(r, st(txq.size(), 0, 0));
            chk(tx_int, 32'(txq.size() <= tx_trigger_level + 1));
        end
        for (int i = 0; i < 16; i++) begin
            sh_u.pop_one(r);
            chk(r, txq.pop_front());
            sh_u.push_one(r);
            rxq.push_back(r);
            @(negedge clk);
            chk(tx_req, 32'(txq.size() <= tx_trigger_level + 1));
            chk(rx_int, 32'(rxq.size() > rx_trigger_level));
            chk(tx_avail, 32'(txq.size() != 0));
        end
        sh_u.push_one(32'h0);
        wb(1'b0, `STATUS_OFS, 32'h0, r);
        chk(r, st(0, 16, 1));
        for (int i = 0; i < 17; i++) begin
            wb(1'b0, `DATA_OFS, 32'h0, r);
            chk(r, i < 16 ? rxq.pop_front() : 0);
        end
        wb(1'b1, `STATUS_OFS, 32'h0040_0000, r);
        wb(1'b0, `STATUS_OFS, 32'h0, r);
        chk(r, st(0, 0, 0));
        $display("unpacked test done");
        m = 2;
        tx_trigger_level = 1;
        rx_trigger_level = 1;
        wb(1'b1, `CTRL1_OFS, 32'h0000_0011, r);
        wb(1'b1, `CTRL0_OFS, 32'h0000_0003, r);
        for (int i = 0; i < 3; i++) begin
            v = $urandom;
            wb(1'b1, `DATA_OFS, v, r);
            txq.push_back(v[15:0]);
            txq.push_back(v[31:16]);
        end
        for (int i = 0; i < 6; i++) begin
            @(negedge clk);
            chk(tx_req, 32'(txq.size() <= (tx_trigger_level + 1) * m));
            sh_u.pop_one(r);
            chk(r, txq.pop_front());
        end
        for (int i = 0; i < 3; i++) begin
            v = $urandom;
            sh_u.push_one(v);
            rxq.push_back(v[15:0]);
            @(negedge clk);
            chk(rx_req, 32'(rxq.size() > rx_trigger_level * m));
        end
        wb(1'b0, `DATA_OFS, 32'h0, r);
        chk(r, 32'(rxq[1] << 16 | rxq[0]));
        $display("packed test done");
        d = $urandom % 3;
        for (int i = 0; i < 7; i++) begin
            wb(1'b1, `CTRL0_OFS, SELS[i] | 32'(d) << 16, r);
            wb(1'b1, `CTRL0_OFS, SELS[i] | 32'(d) << 16 | 32'h1, r);
            repeat (20) @(posedge clk);
            n0 = n_tog;
            repeat (840) @(posedge clk);
            diff = n_tog - n0 - 840 / (2 * HP[EXP[i]]) / (d + 1);
            chk(32'(diff >= -2 && diff <= 2), 32'h1);
            chk(bclk_oe, 32'h1);
        end
        wb(1'b1, `CTRL0_OFS, 32'h0000_0041, r);
        repeat (3) @(posedge clk);
        chk(bclk_oe, 32'h0);
        chk(bclk, 32'h0);
        $display("baud test done");
        final_report();
    end
endmodule // serial_port_fifo_and_baud_gen_bench
`default_nettype wire
